// ### wgs_top.sv
/*
   wgs_top: configuration slice of the four-output waveform generator:
   shutdown sources, steering, clock choice and input multiplexer, with
   an APB register file and one level interrupt.
   assumes: source signals come from outside sys_clk and are synchronised
   here; the clock switch cell outside uses genClkSelect.
*/
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module wgs_top
   import wgs_pkg::*;
(
   input  wire logic        sys_clk,       // system clock 40 MHz
   input  wire logic        rst,           // synchronous reset, high
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb access phase
   input  wire logic        pwrite,        // apb write
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire wgs_src_t    srcIn,         // candidate input sources
   input  wire wgs_shdn_t   shdnIn,        // shutdown sources
   input  wire logic [3:0]  generatorDataWaveform, // data per output
   output logic [3:0]       outLevel,      // output levels a..d
   output logic [3:0]       outEnable,     // output drive enables
   output logic             genInput,      // selected generator input
   output logic             genClkSelect,  // 1 selects fast oscillator
   output logic             irq            // level interrupt
);
   localparam int NSRC = $bits(wgs_src_t); // source count
   localparam int NSHD = $bits(wgs_shdn_t); // shutdown count

   // registers
   logic [7:0] con0_r;                     // enable, load, mode
   logic [3:0] invert_r;                   // polarity a..d
   logic [DB_W-1:0] dbr_r;                 // rise dead-band
   logic [DB_W-1:0] dbf_r;                 // fall dead-band
   logic [7:0] as0_r;                      // shutdown control
   logic [SRC_W-1:0] as1_r;                // shutdown enables
   logic [3:0] overrideData_r;             // override data a..d
   logic [3:0] steerBuf_r;                 // written steering enables
   logic [3:0] steerAct_r;                 // applied steering enables
   logic       clkSel_r;                   // clock select
   logic [IS_W-1:0] isel_r;                // input select
   logic [IRQ_W-1:0] irqSt_r;              // sticky events
   logic [IRQ_W-1:0] irqMsk_r;             // interrupt mask
   logic       hold_r;                     // shutdown hold after clear
   logic       inPrev_r;                   // previous generator input
   logic       shdnPrev_r;                 // previous shutdown flag

   // synchronised inputs
   wgs_src_t   srcS;                       // synchronised sources
   wgs_shdn_t  shdnS;                      // synchronised shutdown

   wgs_sync #(.W(NSRC)) u_syncSrc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn (srcIn),
      .syncOut (srcS)
   );
   wgs_sync #(.W(NSHD)) u_syncShd (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn (shdnIn),
      .syncOut (shdnS)
   );

   // apb decode
   logic       wrEn;                       // write strobe
   logic       rdEn;                       // read strobe
   logic       hit;                        // address mapped
   logic [7:0] wd;                         // write byte
   assign wrEn    = psel & penable & pwrite;
   assign rdEn    = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign wd      = pwdata[7:0];
   always_comb begin
      case (paddr)
         OFF_CON0, OFF_CON1, OFF_DBR, OFF_DBF, OFF_AS0, OFF_AS1,
         OFF_STR, OFF_CLK, OFF_ISM, OFF_IRQST, OFF_IRQMSK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   // input multiplexer, reserved codes give no source
   always_comb begin
      case (isel_r)
         IS_PIN:  genInput = srcS.dedicatedInputPin; // [RULE14]
         IS_CCP1: genInput = srcS.ccpOut[0];
         IS_CCP2: genInput = srcS.ccpOut[1];
         IS_PWM3: genInput = srcS.pwmOut[0];
         IS_PWM4: genInput = srcS.pwmOut[1];
         IS_CMP1: genInput = srcS.cmpOut[0];
         IS_CMP2: genInput = srcS.cmpOut[1];
         IS_LC1:  genInput = srcS.logicCellOut[0];
         IS_LC2:  genInput = srcS.logicCellOut[1];
         IS_LC3:  genInput = srcS.logicCellOut[2];
         IS_LC4:  genInput = srcS.logicCellOut[3];
         default: genInput = 1'b0;          // [RULE15]
      endcase
   end
   assign genClkSelect = clkSel_r;          // [RULE13]

   // shutdown sources gated by enables
   logic [SRC_W-1:0] shdnVec;              // source vector
   logic shdnAny;                          // any enabled source high
   logic inRise;                           // generator input rose
   logic inFall;                           // generator input fell
   logic shdnWr;                           // software writes flag
   assign shdnVec = shdnS;
   assign shdnAny = (shdnVec[4] & as1_r[4])   // [RULE1]
                  | (shdnVec[3] & as1_r[3])   // [RULE2]
                  | (shdnVec[2] & as1_r[2])   // [RULE3]
                  | (shdnVec[1] & as1_r[1])   // [RULE4]
                  | (shdnVec[0] & as1_r[0]);  // [RULE5]
   assign inRise  = genInput & ~inPrev_r;
   assign inFall  = ~genInput & inPrev_r;
   assign shdnWr  = wrEn && paddr == OFF_AS0;

   // edge history of generator input and shutdown flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         inPrev_r   <= 1'b0;
         shdnPrev_r <= 1'b0;
      end else begin
         inPrev_r   <= genInput;
         shdnPrev_r <= as0_r[AS0_SHDN];
      end
   end

   // shutdown control register: set by hardware wins over clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         as0_r <= AS0_RST;
      end else begin
         if (shdnWr) begin
            as0_r <= wd & AS0_WM;
         end
         if (shdnAny) begin
            as0_r[AS0_SHDN] <= 1'b1;        // [RULE6]
         end else if (as0_r[AS0_REN] && !shdnWr) begin
            as0_r[AS0_SHDN] <= 1'b0;        // auto-restart clear
         end
      end
   end

   // hold shutdown levels from clear until next rising input
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_r <= 1'b0;
      end else if (as0_r[AS0_SHDN]) begin
         hold_r <= 1'b1;                    // [RULE7]
      end else if (hold_r && inRise) begin
         hold_r <= 1'b0;                    // [RULE7]
      end
   end

   // control register zero: load bit cleared after transfer
   logic loadDone;                         // buffered values moved
   assign loadDone = con0_r[CON0_LD] & (inRise | inFall); // [RULE12]
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         con0_r <= ZERO8;
      end else if (wrEn && paddr == OFF_CON0) begin
         con0_r <= wd & CON0_WM;
         // load may only be set while already enabled
         con0_r[CON0_LD] <= wd[CON0_LD] & con0_r[CON0_EN];
      end else if (loadDone) begin
         con0_r[CON0_LD] <= 1'b0;           // [RULE12]
      end
   end

   // plain configuration registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         invert_r       <= '0;
         dbr_r          <= '0;
         dbf_r          <= '0;
         as1_r          <= '0;
         overrideData_r <= '0;
         steerBuf_r     <= '0;
         clkSel_r       <= 1'b0;
         isel_r         <= '0;
         irqMsk_r       <= '0;
      end else if (wrEn) begin
         case (paddr)
            OFF_CON1: invert_r <= wd[NOUT-1:0];
            OFF_DBR:  dbr_r    <= wd[DB_W-1:0];   // [RULE16]
            OFF_DBF:  dbf_r    <= wd[DB_W-1:0];   // [RULE16]
            OFF_AS1:  as1_r    <= wd[SRC_W-1:0];
            OFF_STR: begin
               overrideData_r <= wd[2*NOUT-1:NOUT];
               steerBuf_r     <= wd[NOUT-1:0];    // [RULE11]
            end
            OFF_CLK:  clkSel_r <= wd[0];
            OFF_ISM:  isel_r   <= wd[IS_W-1:0];
            OFF_IRQMSK: irqMsk_r <= wd[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // applied steering: buffered in synchronous steering, direct in every other mode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         steerAct_r <= '0;
      end else if (con0_r[2:0] != MODE_SSTEER) begin
         steerAct_r <= steerBuf_r;
      end else if (loadDone) begin
         steerAct_r <= steerBuf_r;          // [RULE11] [RULE12]
      end
   end

   // sticky interrupt status, set beats write-one clear
   logic [IRQ_W-1:0] irqSet;               // events this cycle
   assign irqSet[IRQ_SHDN] = as0_r[AS0_SHDN] & ~shdnPrev_r;
   assign irqSet[IRQ_LOAD] = loadDone;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqSt_r <= '0;
      end else if (wrEn && paddr == OFF_IRQST) begin
         irqSt_r <= (irqSt_r & ~wd[IRQ_W-1:0]) | irqSet;
      end else begin
         irqSt_r <= irqSt_r | irqSet;
      end
   end
   assign irq = |(irqSt_r & irqMsk_r);

   // output stage per output
   logic steerMode;                        // modes 00x active
   logic inShdn;                           // shutdown levels forced
   assign steerMode = con0_r[2:1] == MODE_STEER[2:1]; // [RULE10]
   assign inShdn    = as0_r[AS0_SHDN] | hold_r;
   logic [3:0] lvlNxt;                     // next levels
   logic [3:0] oeNxt;                      // next enables
   genvar k;
   generate
      for (k = 0; k < NOUT; k++) begin : g_out
         logic [1:0] sc;                   // shutdown state code
         logic       norm;                 // normal waveform level
         assign sc = (k % 2 == 0) ? as0_r[3:2] : as0_r[5:4];
         always_comb begin
            norm = generatorDataWaveform[k] ^ invert_r[k];
            if (steerMode && !steerAct_r[k]) begin
               norm = overrideData_r[k];    // [RULE9] [RULE10]
            end
            lvlNxt[k] = norm;               // [RULE8]
            oeNxt[k]  = con0_r[CON0_EN];
            if (inShdn) begin
               case (sc)                    // [RULE6]
                  2'b11: lvlNxt[k] = 1'b1;
                  2'b10: lvlNxt[k] = 1'b0;
                  2'b01: oeNxt[k]  = 1'b0;
                  default: lvlNxt[k] = invert_r[k];
               endcase
            end
         end
      end
   endgenerate

   // registered outputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         outLevel  <= '0;
         outEnable <= '0;
      end else begin
         outLevel  <= lvlNxt;
         outEnable <= oeNxt;
      end
   end

   // read mux
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata <= '0;
      end else begin
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               OFF_CON0: prdata[7:0] <= con0_r;
               OFF_CON1: prdata[7:0] <= {2'b00, genInput, 1'b0, invert_r};
               OFF_DBR:  prdata[DB_W-1:0] <= dbr_r;
               OFF_DBF:  prdata[DB_W-1:0] <= dbf_r;
               OFF_AS0:  prdata[7:0] <= as0_r;
               OFF_AS1:  prdata[SRC_W-1:0] <= as1_r;
               OFF_STR:  prdata[7:0] <= {overrideData_r, steerBuf_r};
               OFF_CLK:  prdata[0] <= clkSel_r;
               OFF_ISM:  prdata[IS_W-1:0] <= isel_r;
               OFF_IRQST:  prdata[IRQ_W-1:0] <= irqSt_r;
               OFF_IRQMSK: prdata[IRQ_W-1:0] <= irqMsk_r;
               default: ;
            endcase
         end
      end
   end
   logic unusedRd;                         // read strobe kept for clarity
   assign unusedRd = rdEn;
endmodule // wgs_top

// ### wgs_pkg.sv
/*
   wgs_pkg: shared constants and types for the waveform generator
   steering and shutdown configuration slice.
   assumes: an APB slave with 32-bit data and one register per aligned word.
*/
// Summary of operation
// RULE1 - logic cell 2 shutdown honoured when enabled
// RULE2 - comparator 2 shutdown honoured when enabled
// RULE3 - comparator 1 shutdown honoured when enabled
// RULE4 - timer 2 postscale shutdown honoured when enabled
// RULE5 - selected input pin shutdown honoured when enabled
// RULE6 - enabled source sets flag, forces shutdown levels
// RULE7 - after clear, hold shutdown until input rises
// RULE8 - steer enabled: data waveform with own polarity
// RULE9 - steer disabled: output takes override data bit
// RULE10 - steering bits act only in modes 00x
// RULE11 - synchronous steering buffers steering enable writes
// RULE12 - load bit transfers on next edge, self-clears
// RULE13 - clock select: fast oscillator or system clock
// RULE14 - input select field picks generator source
// RULE15 - codes 1011 to 1111 connect nothing
// RULE16 - dead-band registers hold six-bit counts
package wgs_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_CON0   = 12'h000;
   localparam logic [11:0] OFF_CON1   = 12'h004;
   localparam logic [11:0] OFF_DBR    = 12'h008;
   localparam logic [11:0] OFF_DBF    = 12'h00C;
   localparam logic [11:0] OFF_AS0    = 12'h010;
   localparam logic [11:0] OFF_AS1    = 12'h014;
   localparam logic [11:0] OFF_STR    = 12'h018;
   localparam logic [11:0] OFF_CLK    = 12'h01C;
   localparam logic [11:0] OFF_ISM    = 12'h020;
   localparam logic [11:0] OFF_IRQST  = 12'h024;
   localparam logic [11:0] OFF_IRQMSK = 12'h028;
   // field positions
   localparam int CON0_EN    = 7;
   localparam int CON0_LD    = 6;
   localparam int AS0_SHDN   = 7;
   localparam int AS0_REN    = 6;
   localparam int CON1_IN    = 5;
   localparam int DB_W       = 6;
   localparam int SRC_W      = 5;
   localparam int IS_W       = 4;
   localparam int NOUT       = 4;
   // reset values
   localparam logic [7:0] AS0_RST = 8'h14;
   localparam logic [7:0] ZERO8   = 8'h00;
   // write masks
   localparam logic [7:0] CON0_WM = 8'hC7;
   localparam logic [7:0] CON1_WM = 8'h0F;
   localparam logic [7:0] AS0_WM  = 8'hFC;
   localparam logic [7:0] AS1_WM  = 8'h1F;
   localparam logic [7:0] DB_WM   = 8'h3F;
   localparam logic [7:0] CLK_WM  = 8'h01;
   localparam logic [7:0] ISM_WM  = 8'h0F;
   // interrupt status bits
   localparam int IRQ_SHDN = 0;
   localparam int IRQ_LOAD = 1;
   localparam int IRQ_W    = 2;
   // mode encodings
   localparam logic [2:0] MODE_STEER  = 3'h0;
   localparam logic [2:0] MODE_SSTEER = 3'h1;
   // input select codes
   localparam logic [3:0] IS_PIN   = 4'h0;
   localparam logic [3:0] IS_CCP1  = 4'h1;
   localparam logic [3:0] IS_CCP2  = 4'h2;
   localparam logic [3:0] IS_PWM3  = 4'h3;
   localparam logic [3:0] IS_PWM4  = 4'h4;
   localparam logic [3:0] IS_CMP1  = 4'h5;
   localparam logic [3:0] IS_CMP2  = 4'h6;
   localparam logic [3:0] IS_LC1   = 4'h7;
   localparam logic [3:0] IS_LC2   = 4'h8;
   localparam logic [3:0] IS_LC3   = 4'h9;
   localparam logic [3:0] IS_LC4   = 4'hA;
   // candidate input sources to the generator
   typedef struct packed {
      logic       dedicatedInputPin; // dedicated pin
      logic [1:0] ccpOut;            // capture/compare 2..1
      logic [1:0] pwmOut;            // pwm 4..3
      logic [1:0] cmpOut;            // comparators 2..1
      logic [3:0] logicCellOut;      // logic cells 4..1
   } wgs_src_t;
   // shutdown sources, bit order matches enable register
   typedef struct packed {
      logic logicCell2Output;        // bit 4
      logic comparator2;             // bit 3
      logic comparator1;             // bit 2
      logic timer2Postscale;         // bit 1
      logic inputPinSelector;        // bit 0
   } wgs_shdn_t;
endpackage

// ### wgs_sync.sv
/*
   wgs_sync: three-stage synchroniser with agreement filter, one per bit.
   assumes: inputs asynchronous to sys_clk; output changes once stages
   two and three agree.
*/
`timescale 1ns/1ps
module wgs_sync #(
   parameter int W = 1                     // number of bits
) (
   input  wire logic         sys_clk,      // system clock
   input  wire logic         rst,          // synchronous reset
   input  wire logic [W-1:0] asyncIn,      // raw inputs
   output logic      [W-1:0] syncOut       // filtered outputs
);
   logic [W-1:0] s1_r;                     // first stage only
   logic [W-1:0] s2_r;                     // second stage
   logic [W-1:0] s3_r;                     // third stage
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // shift chain and agreement filter per bit
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               s1_r[i]    <= 1'b0;
               s2_r[i]    <= 1'b0;
               s3_r[i]    <= 1'b0;
               syncOut[i] <= 1'b0;
            end else begin
               s1_r[i] <= asyncIn[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               if (s2_r[i] == s3_r[i]) begin
                  syncOut[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate
endmodule // wgs_sync

// ### wgs_checker.sv
/*
   wgs_checker: port assertions for wgs_top.
   assumes: bound to wgs_top; shutdown levels stay at reset (tristate).
*/
`timescale 1ns/1ps
module wgs_checker
   import wgs_pkg::*;
(
   input wire logic        sys_clk,               // clock
   input wire logic        rst,                   // sync reset
   input wire logic        psel,                  // apb select
   input wire logic        penable,               // apb access
   input wire logic        pwrite,                // apb write
   input wire logic [11:0] paddr,                 // apb address
   input wire logic [31:0] pwdata,                // apb write data
   input wire logic [31:0] prdata,                // apb read data
   input wire logic        pready,                // apb ready
   input wire logic        pslverr,               // apb error
   input wire wgs_src_t    srcIn,                 // input sources
   input wire wgs_shdn_t   shdnIn,                // shutdown sources
   input wire logic [3:0]  generatorDataWaveform, // data a..d
   input wire logic [3:0]  outLevel,              // levels a..d
   input wire logic [3:0]  outEnable,             // enables a..d
   input wire logic        genInput,              // chosen input
   input wire logic        genClkSelect,          // clock choice
   input wire logic        irq                    // interrupt
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic       wrEn;     // a write takes effect
   logic [4:0] as1R;     // shadow of source enables
   logic [3:0] ismR;     // shadow of input select
   logic [7:0] strR;     // shadow of steering
   logic [7:0] con0R;    // shadow of control zero
   logic [3:0] polR;     // shadow of polarity
   logic [1:0] mskR;     // shadow of interrupt mask
   logic       seenR;    // an enabled source was seen
   logic [3:0] steerExp; // expected steered level
   logic [3:0] steerD;   // enables one cycle late, as applied
   assign wrEn = psel & penable & pwrite;
   assign steerExp = (steerD & (generatorDataWaveform ^ polR))
                   | (~steerD & strR[7:4]);
   // plain steering applies written enables on the following edge
   always_ff @(posedge sys_clk) begin
      if (rst) steerD <= '0;
      else steerD <= strR[3:0];
   end
   // shadows follow software writes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         as1R <= '0;
         ismR <= '0;
         strR <= '0;
         con0R <= '0;
         polR <= '0;
         mskR <= '0;
      end else if (wrEn) begin
         case (paddr)
            OFF_AS1: as1R <= pwdata[4:0];
            OFF_ISM: ismR <= pwdata[3:0];
            OFF_STR: strR <= pwdata[7:0];
            OFF_CON0: con0R <= pwdata[7:0];
            OFF_CON1: polR <= pwdata[3:0];
            OFF_IRQMSK: mskR <= pwdata[1:0];
            default: ;
         endcase
      end
   end
   // once a shutdown may have begun, steering is no longer judged
   always_ff @(posedge sys_clk) begin
      if (rst) seenR <= 1'b0;
      else if (|(shdnIn & as1R)) seenR <= 1'b1;
   end
   property p_clk_sel;
      wrEn && paddr == OFF_CLK |=> genClkSelect == $past(pwdata[0]);
   endproperty
   a_clk_sel: assert property (p_clk_sel)
      else $error("clock select does not follow write");
   property p_clk_rst;
      $fell(rst) |-> !genClkSelect;
   endproperty
   a_clk_rst: assert property (p_clk_rst)
      else $error("clock select not zero after reset");
   property p_reserved;
      ismR >= 4'hB |-> !genInput;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved input code passes a source");
   property p_pin;
      (ismR == IS_PIN && srcIn.dedicatedInputPin)[*6] |-> genInput;
   endproperty
   a_pin: assert property (p_pin)
      else $error("dedicated pin not selected");
   property p_cmp;
      (ismR == IS_CMP2 && srcIn.cmpOut[1])[*6] |-> genInput;
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("comparator two not selected");
   property p_lc;
      (ismR == IS_LC4 && !srcIn.logicCellOut[3])[*6] |-> !genInput;
   endproperty
   a_lc: assert property (p_lc)
      else $error("logic cell four low but input high");
   property p_shdn;
      (|(shdnIn & as1R))[*6] |-> ##[0:3] outEnable == 4'h0;
   endproperty
   a_shdn: assert property (p_shdn)
      else $error("enabled source did not shut outputs");
   property p_steer;
      con0R[7] && con0R[2:0] == MODE_STEER && !seenR
         |=> outLevel == $past(steerExp);
   endproperty
   a_steer: assert property (p_steer)
      else $error("steered level wrong");
   property p_irq;
      mskR == 2'b00 |-> !irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("masked interrupt raised");
   c_sync: cover property (con0R[2:0] == MODE_SSTEER && genInput);
   c_shdn: cover property (outEnable == 4'h0 && seenR);
   c_irq: cover property (irq);
endmodule // wgs_checker

// ### wgs_stage.sv
/*
   wgs_stage: power stage model resolving each pin.
   assumes: a released pin floats; shown as a toggling level.
*/
`timescale 1ns/1ps
module wgs_stage (
   input  wire logic       sys_clk,   // clock
   input  wire logic [3:0] outLevel,  // driven levels a..d
   input  wire logic [3:0] outEnable, // drive enables a..d
   output logic      [3:0] pinLevel   // resolved pins
);
   logic [3:0] lastR = 4'h0; // last pin level
   // floating pins never hold a stale value
   always @(posedge sys_clk) begin
      lastR <= pinLevel;
   end
   assign pinLevel = (outEnable & outLevel) | (~outEnable & ~lastR);
endmodule // wgs_stage

// ### wgs_top_tb_top.sv
/*
   wgs_top_tb_top: scenario bench for the steering and shutdown slice.
   assumes: apb slave answers with pready; shutdown levels left tristate.
*/
`timescale 1ns/1ps
module wgs_top_tb_top
   import wgs_pkg::*;
;
   logic        sys_clk, rst, psel, penable, pwrite, rerr;
   logic        pready, pslverr, genInput, genClkSelect, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  genData, outLevel, outEnable, pinLevel;
   wgs_src_t    srcIn;
   wgs_shdn_t   shdnIn;
   int          failures = 0, n_tests = 0, cyc = 0;
   int          srcPos [11] = '{10, 8, 9, 6, 7, 4, 5, 0, 1, 2, 3};
   wgs_top uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .srcIn(srcIn),
      .shdnIn(shdnIn), .generatorDataWaveform(genData),
      .outLevel(outLevel), .outEnable(outEnable), .genInput(genInput),
      .genClkSelect(genClkSelect), .irq(irq));
   wgs_stage stage (.sys_clk(sys_clk), .outLevel(outLevel),
      .outEnable(outEnable), .pinLevel(pinLevel));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic t_regs();
      rd(OFF_AS0);
      chk(rdat, 32'h0000_0014);
      wr(OFF_DBR, 32'hFFFF_FFFF);
      rd(OFF_DBR);
      chk(rdat, 32'h0000_003F);
      wr(OFF_DBF, 32'h0000_00EA);
      rd(OFF_DBF);
      chk(rdat, 32'h0000_002A);
      rd(12'h0FC);
      chk({31'h0000_0000, rerr}, 32'h0000_0001);
      chk(rdat, 32'h0000_0000);
   endtask
   task automatic t_clk();
      chk(genClkSelect, 1'b0);
      wr(OFF_CLK, 32'h0000_0001);
      tick(1);
      chk(genClkSelect, 1'b1);
      wr(OFF_CLK, 32'h0000_0000);
      tick(1);
      chk(genClkSelect, 1'b0);
   endtask
   // each code: only its source high (none for codes 11 to 15), then all others high
   task automatic t_ism();
      logic [10:0] sel;
      for (int c = 0; c < 16; c++) begin
         sel = (c < 11) ? (11'h001 << srcPos[c]) : 11'h000;
         wr(OFF_ISM, 32'(c));
         srcIn <= sel;
         tick(6);
         chk(genInput, c < 11);
         srcIn <= ~sel;
         tick(6);
         chk(genInput, 1'b0);
      end
      srcIn <= '0;
      wr(OFF_ISM, 32'h0000_0000);
   endtask
   task automatic t_steer();
      logic [3:0] e;
      wr(OFF_CON0, 32'h0000_0080);
      wr(OFF_CON1, 32'h0000_0005);
      wr(OFF_STR, 32'h0000_00A3);
      for (int d = 0; d < 16; d++) begin
         genData <= 4'(d);
         tick(3);
         e = (4'h3 & (4'(d) ^ 4'h5)) | (4'hC & 4'hA);
         chk(outLevel, e);
         chk(pinLevel, e);
      end
      wr(OFF_CON0, 32'h0000_0084);
      genData <= 4'h0;
      tick(3);
      chk(outLevel, 4'h5);
   endtask
   // buffered steering applies only at the input edge after load
   task automatic t_sync();
      wr(OFF_CON0, 32'h0000_0081);
      genData <= 4'h0;
      wr(OFF_STR, 32'h0000_0000);
      tick(3);
      chk(outLevel, 4'h1);
      wr(OFF_CON0, 32'h0000_00C1);
      rd(OFF_CON0);
      chk(rdat, 32'h0000_00C1);
      chk(outLevel, 4'h1);
      srcIn <= 11'h400;
      tick(8);
      rd(OFF_CON0);
      chk(rdat, 32'h0000_0081);
      chk(outLevel, 4'h0);
      srcIn <= '0;
      tick(6);
   endtask
   task automatic t_shdn();
      for (int i = 0; i < 5; i++) begin
         wr(OFF_IRQMSK, 32'(i != 0));
         wr(OFF_AS1, 32'h0000_0001 << i);
         shdnIn <= ~(5'h01 << i);
         tick(8);
         chk(outEnable, 4'hF);
         shdnIn <= '1;
         tick(8);
         chk(outEnable, 4'h0);
         rd(OFF_AS0);
         chk(rdat, 32'h0000_0094);
         chk(irq, i != 0);
         shdnIn <= '0;
         tick(6);
         wr(OFF_AS0, 32'h0000_0014);
         wr(OFF_IRQST, 32'h0000_0003);
         tick(4);
         chk(irq, 1'b0);
         chk(outEnable, 4'h0);
         srcIn <= 11'h400;
         tick(8);
         chk(outEnable, 4'hF);
         srcIn <= '0;
         tick(6);
      end
   endtask
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      srcIn = '0;
      shdnIn = '0;
      genData = 4'h0;
      tick(16);
      rst <= 1'b0;
      t_regs();
      t_clk();
      t_ism();
      t_steer();
      t_sync();
      t_shdn();
      test_done();
   end
endmodule // wgs_top_tb_top
bind wgs_top wgs_checker chk_i (.sys_clk(sys_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .srcIn(srcIn), .shdnIn(shdnIn),
   .generatorDataWaveform(generatorDataWaveform), .outLevel(outLevel),
   .outEnable(outEnable), .genInput(genInput),
   .genClkSelect(genClkSelect), .irq(irq));
